// ===== common/smbr_pkg.sv
// Package for the synthesizer modulator and bias register slice.
// Assumes byte-wide registers written from the serial port decoder.
package smbr_pkg;
    // Register offsets
    localparam logic [7:0] SMBR_OFS_BLEED = 8'h2A;
    localparam logic [7:0] SMBR_OFS_MOD = 8'h2B;
    localparam logic [7:0] SMBR_OFS_CORE_D = 8'h2C;
    localparam logic [7:0] SMBR_OFS_CORE_C = 8'h2D;
    localparam logic [7:0] SMBR_OFS_CORE_B = 8'h2E;
    // Primary fraction word register, whose update resets the modulator
    localparam logic [7:0] SMBR_OFS_FRAC = 8'h10;
    localparam int SMBR_NREG = 5;
    // Values after reset, indexed from the first offset
    localparam logic [7:0] SMBR_RESET [SMBR_NREG] =
        '{8'h00, 8'h01, 8'h44, 8'h11, 8'h10};
    // Writable bits; the rest read as zero
    localparam logic [7:0] SMBR_WMASK [SMBR_NREG] =
        '{8'h29, 8'h35, 8'h7F, 8'h1F, 8'h1F};
    // Register indices
    localparam int SMBR_IX_BLEED = 0;
    localparam int SMBR_IX_MOD = 1;
    localparam int SMBR_IX_CORE_D = 2;
    localparam int SMBR_IX_CORE_C = 3;
    localparam int SMBR_IX_CORE_B = 4;
    // Field positions, bleed and readback register
    localparam int SMBR_BLEED_POLARITY_BIT = 5;
    localparam int SMBR_LATCH_SEL_BIT = 3;
    localparam int SMBR_READ_SEL_BIT = 0;
    // Field positions, modulator register
    localparam int SMBR_HALF_LSB_BIT = 5;
    localparam int SMBR_AUX_EN_BIT = 4;
    localparam int SMBR_RST_MASK_BIT = 2;
    localparam int SMBR_MOD_DIS_BIT = 0;
    // Field positions, core D and calibration register
    localparam int SMBR_D_RECT_BIT = 6;
    localparam int SMBR_D_RANGE_BIT = 5;
    localparam int SMBR_D_NOM_LSB = 2;
    localparam int SMBR_CAL_EN_BIT = 1;
    localparam int SMBR_LOOP_DIS_BIT = 0;
    // Field positions, core C and core B registers
    localparam int SMBR_CB_RECT_BIT = 4;
    localparam int SMBR_CB_RANGE_BIT = 3;
    localparam int SMBR_CB_NOM_LSB = 0;
    // Bias settings of one VCO core
    typedef struct packed {
        logic rectifier_bias;
        logic threshold_range;
        logic [2:0] nominal_threshold;
    } smbr_core_t;
    // Decoded controls toward the analog and modulator logic
    typedef struct packed {
        logic bleed_polarity;
        logic latch_select_reserved;
        logic half_lsb_add;
        logic aux_modulator_enable;
        logic modulator_run;
        logic auto_bias_loop_run;
        logic temp_cal_voltage_enable;
        smbr_core_t core_d;
        smbr_core_t core_c;
        smbr_core_t core_b;
    } smbr_ctrl_t;
endpackage

// ===== src/smbr_regs.sv
// Modulator and VCO bias register slice with its decoded controls.
// Assumes a same-clock register port from the serial interface decoder.
`timescale 1ns/100ps

// Notes on behaviour
// RL1: Bleed bit 5 selects bleed polarity.
// RL2: Readback select picks VCO data or version.
// RL3: Half LSB added only with aux off.
// RL4: Software enables aux modulator for nonzero fraction.
// RL5: Fraction write resets modulator unless masked.
// RL6: Modulator bit inverted: one means integer.
// RL7: Bias loop runs while disable bit clear.
// RL8: Calibration option enables temperature dependence.
// RL9: Core D rectifier bias at bit 6.
// RL10: Core D threshold range at bit 5.
// RL11: Core D nominal threshold bits 4:2.
// RL12: Core C rectifier bias at bit 4.
// RL13: Core C threshold range at bit 3.
// RL14: Core C nominal threshold bits 2:0.
// RL15: Core B rectifier bias at bit 4.
// RL16: Core B threshold range at bit 3.
// RL17: Core B nominal threshold bits 2:0.
// RL18: Reserved bits read zero, ignore writes.
module smbr_regs
    import smbr_pkg::*;
#(
    parameter logic [7:0] VERSION_ID = 8'hA5 // Arbitrary value
) (
    input wire logic CORE_CLK_IN, // Core clock
    input wire logic RST_IN, // Synchronous reset
    input wire logic REG_WR_IN, // Write strobe
    input wire logic REG_RD_IN, // Read strobe
    input wire logic [7:0] REG_ADDR_IN, // Register address
    input wire logic [7:0] REG_WDATA_IN, // Write data
    input wire logic [7:0] VCO_STATUS_IN, // VCO, band, bias data
    output logic [7:0] REG_RDATA_OUT, // Read data
    output logic REG_RVALID_OUT, // Read data valid pulse
    output logic [7:0] READBACK_OUT, // Selected readback word
    output logic MOD_RESET_OUT, // Modulator reset pulse
    output smbr_ctrl_t CTRL_OUT // Decoded controls
);
    // Register storage, indexed from the first offset
    logic [7:0] regs [SMBR_NREG];
    // Address lands inside the slice
    logic hit;
    // Index into the storage
    logic [2:0] idx;
    // Decoded controls before their output flops
    smbr_ctrl_t next_ctrl;
    // Readback word before its output flop
    logic [7:0] next_readback;

    // Address decode
    assign hit = (REG_ADDR_IN >= SMBR_OFS_BLEED) &&
                 (REG_ADDR_IN <= SMBR_OFS_CORE_B);
    assign idx = 3'(REG_ADDR_IN - SMBR_OFS_BLEED);

    // Register writes, masked to writable bits
    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            for (int i = 0; i < SMBR_NREG; i++) begin
                regs[i] <= SMBR_RESET[i];
            end
        end else if (REG_WR_IN && hit) begin
            // RL18: reserved bits dropped
            regs[idx] <= REG_WDATA_IN & SMBR_WMASK[idx];
        end
    end

    // Register reads, one cycle after the strobe
    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            REG_RDATA_OUT <= 8'h00;
            REG_RVALID_OUT <= 1'b0;
        end else begin
            REG_RVALID_OUT <= REG_RD_IN;
            if (REG_RD_IN && hit) begin
                // RL18: reserved bits read zero
                REG_RDATA_OUT <= regs[idx] & SMBR_WMASK[idx];
            end else if (REG_RD_IN) begin
                // Unmapped address reads zero
                REG_RDATA_OUT <= 8'h00;
            end
        end
    end

    // Modulator reset on fraction word update
    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            MOD_RESET_OUT <= 1'b0;
        end else begin
            // RL5: masked by reset-mask bit
            MOD_RESET_OUT <= REG_WR_IN &&
                (REG_ADDR_IN == SMBR_OFS_FRAC) &&
                !regs[SMBR_IX_MOD][SMBR_RST_MASK_BIT];
        end
    end

    // Readback source selection
    always_comb begin
        // RL2: version or VCO data
        if (regs[SMBR_IX_BLEED][SMBR_READ_SEL_BIT]) begin
            next_readback = VERSION_ID;
        end else begin
            next_readback = VCO_STATUS_IN;
        end
    end

    // Readback output flop
    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            READBACK_OUT <= 8'h00;
        end else begin
            READBACK_OUT <= next_readback;
        end
    end

    // Control decode
    always_comb begin
        // RL1: bleed polarity bit
        next_ctrl.bleed_polarity =
            regs[SMBR_IX_BLEED][SMBR_BLEED_POLARITY_BIT];
        next_ctrl.latch_select_reserved =
            regs[SMBR_IX_BLEED][SMBR_LATCH_SEL_BIT];
        // RL3: half LSB gated by aux
        next_ctrl.half_lsb_add =
            regs[SMBR_IX_MOD][SMBR_HALF_LSB_BIT] &&
            !regs[SMBR_IX_MOD][SMBR_AUX_EN_BIT];
        // RL4: aux enable passed as written
        next_ctrl.aux_modulator_enable =
            regs[SMBR_IX_MOD][SMBR_AUX_EN_BIT];
        // RL6: inverted modulator enable
        next_ctrl.modulator_run =
            !regs[SMBR_IX_MOD][SMBR_MOD_DIS_BIT];
        // RL7: inverted bias loop disable
        next_ctrl.auto_bias_loop_run =
            !regs[SMBR_IX_CORE_D][SMBR_LOOP_DIS_BIT];
        // RL8: temperature calibration option
        next_ctrl.temp_cal_voltage_enable =
            regs[SMBR_IX_CORE_D][SMBR_CAL_EN_BIT];
        // RL9: core D rectifier bias
        next_ctrl.core_d.rectifier_bias =
            regs[SMBR_IX_CORE_D][SMBR_D_RECT_BIT];
        // RL10: core D threshold range
        next_ctrl.core_d.threshold_range =
            regs[SMBR_IX_CORE_D][SMBR_D_RANGE_BIT];
        // RL11: core D nominal threshold
        next_ctrl.core_d.nominal_threshold =
            regs[SMBR_IX_CORE_D][SMBR_D_NOM_LSB +: 3];
        // RL12: core C rectifier bias
        next_ctrl.core_c.rectifier_bias =
            regs[SMBR_IX_CORE_C][SMBR_CB_RECT_BIT];
        // RL13: core C threshold range
        next_ctrl.core_c.threshold_range =
            regs[SMBR_IX_CORE_C][SMBR_CB_RANGE_BIT];
        // RL14: core C nominal threshold
        next_ctrl.core_c.nominal_threshold =
            regs[SMBR_IX_CORE_C][SMBR_CB_NOM_LSB +: 3];
        // RL15: core B rectifier bias
        next_ctrl.core_b.rectifier_bias =
            regs[SMBR_IX_CORE_B][SMBR_CB_RECT_BIT];
        // RL16: core B threshold range
        next_ctrl.core_b.threshold_range =
            regs[SMBR_IX_CORE_B][SMBR_CB_RANGE_BIT];
        // RL17: core B nominal threshold
        next_ctrl.core_b.nominal_threshold =
            regs[SMBR_IX_CORE_B][SMBR_CB_NOM_LSB +: 3];
    end

    // Control output flops
    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            CTRL_OUT <= '0;
        end else begin
            CTRL_OUT <= next_ctrl;
        end
    end

    // Checks on the register slice
    default clocking cb @(posedge CORE_CLK_IN);
    endclocking
    default disable iff (RST_IN);

    // A write to one register address, inside or outside the slice
    sequence wr_s(logic [7:0] a);
        REG_WR_IN && REG_ADDR_IN == a;
    endsequence

    // A read one cycle later to the same address
    sequence rd_next_s(logic [7:0] a);
        ##1 (REG_RD_IN && !REG_WR_IN && REG_ADDR_IN == a);
    endsequence

    bleed_polarity_a: assert property ( // RL1
        wr_s(SMBR_OFS_BLEED) ##2 !REG_WR_IN |->
        CTRL_OUT.bleed_polarity == $past(REG_WDATA_IN[5], 2))
        else $error("bleed polarity not taken from bit 5");

    readback_sel_a: assert property ( // RL2
        ##1 regs[SMBR_IX_BLEED][0] |=> READBACK_OUT == VERSION_ID)
        else $error("readback select ignored");

    half_lsb_a: assert property ( // RL3
        CTRL_OUT.half_lsb_add |->
        $past(regs[SMBR_IX_MOD][5] && !regs[SMBR_IX_MOD][4]))
        else $error("half LSB active with aux on or bit clear");

    mod_reset_a: assert property ( // RL5
        wr_s(SMBR_OFS_FRAC) |=>
        MOD_RESET_OUT == !$past(regs[SMBR_IX_MOD][2]))
        else $error("modulator reset mask misapplied");

    mod_reset_cause_a: assert property ( // RL5
        MOD_RESET_OUT |-> $past(REG_WR_IN) &&
        $past(REG_ADDR_IN) == SMBR_OFS_FRAC)
        else $error("modulator reset without fraction write");

    // Decode checks skip the edge after reset, where the flops read zero
    mod_invert_a: assert property ( // RL6
        !$past(RST_IN) |->
        CTRL_OUT.modulator_run != $past(regs[SMBR_IX_MOD][0]))
        else $error("modulator enable not inverted");

    bias_loop_a: assert property ( // RL7
        !$past(RST_IN) |-> CTRL_OUT.auto_bias_loop_run ==
        !$past(regs[SMBR_IX_CORE_D][0]))
        else $error("bias loop disable not inverted");

    core_d_nom_a: assert property ( // RL11
        wr_s(SMBR_OFS_CORE_D) ##2 !REG_WR_IN |->
        CTRL_OUT.core_d.nominal_threshold ==
        $past(REG_WDATA_IN[4:2], 2))
        else $error("core D threshold field misplaced");

    core_c_nom_a: assert property ( // RL14
        wr_s(SMBR_OFS_CORE_C) ##2 !REG_WR_IN |->
        CTRL_OUT.core_c.nominal_threshold ==
        $past(REG_WDATA_IN[2:0], 2))
        else $error("core C threshold field misplaced");

    // Field placement, looked at two cycles after the write
    core_c_rect_a: assert property ( // RL12
        wr_s(SMBR_OFS_CORE_C) ##2 !REG_WR_IN |->
        CTRL_OUT.core_c.rectifier_bias == $past(REG_WDATA_IN[4], 2))
        else $error("core C rectifier bit misplaced");

    core_c_range_a: assert property ( // RL13
        wr_s(SMBR_OFS_CORE_C) ##2 !REG_WR_IN |->
        CTRL_OUT.core_c.threshold_range == $past(REG_WDATA_IN[3], 2))
        else $error("core C range bit misplaced");

    core_d_rect_a: assert property ( // RL9
        wr_s(SMBR_OFS_CORE_D) ##2 !REG_WR_IN |->
        CTRL_OUT.core_d.rectifier_bias == $past(REG_WDATA_IN[6], 2))
        else $error("core D rectifier bit misplaced");

    core_d_range_a: assert property ( // RL10
        wr_s(SMBR_OFS_CORE_D) ##2 !REG_WR_IN |->
        CTRL_OUT.core_d.threshold_range == $past(REG_WDATA_IN[5], 2))
        else $error("core D range bit misplaced");

    cal_voltage_a: assert property ( // RL8
        wr_s(SMBR_OFS_CORE_D) ##2 !REG_WR_IN |->
        CTRL_OUT.temp_cal_voltage_enable == $past(REG_WDATA_IN[1], 2))
        else $error("calibration option not taken from bit 1");

    core_b_rect_a: assert property ( // RL15
        wr_s(SMBR_OFS_CORE_B) ##2 !REG_WR_IN |->
        CTRL_OUT.core_b.rectifier_bias == $past(REG_WDATA_IN[4], 2))
        else $error("core B rectifier bit misplaced");

    core_b_nom_a: assert property ( // RL17
        wr_s(SMBR_OFS_CORE_B) ##2 !REG_WR_IN |->
        CTRL_OUT.core_b.nominal_threshold ==
        $past(REG_WDATA_IN[2:0], 2))
        else $error("core B threshold field misplaced");

    core_b_range_a: assert property ( // RL16
        wr_s(SMBR_OFS_CORE_B) ##2 !REG_WR_IN |->
        CTRL_OUT.core_b.threshold_range == $past(REG_WDATA_IN[3], 2))
        else $error("core B range bit misplaced");

    reserved_zero_a: assert property ( // RL18
        wr_s(SMBR_OFS_MOD) ##0 rd_next_s(SMBR_OFS_MOD) |=>
        REG_RDATA_OUT == ($past(REG_WDATA_IN, 2) & 8'h35))
        else $error("reserved bits not read as zero");

    read_valid_a: assert property ( // RL2
        REG_RD_IN |=> REG_RVALID_OUT)
        else $error("read valid pulse missing");

    read_valid_once_a: assert property ( // RL2
        !REG_RD_IN |=> !REG_RVALID_OUT)
        else $error("read valid longer than one cycle");

    readback_vco_a: assert property ( // RL2
        ##1 !regs[SMBR_IX_BLEED][0] |=>
        READBACK_OUT == $past(VCO_STATUS_IN))
        else $error("readback not showing VCO data");

    unmapped_zero_a: assert property ( // RL18
        REG_RD_IN && (REG_ADDR_IN < SMBR_OFS_BLEED ||
        REG_ADDR_IN > SMBR_OFS_CORE_B) |=> REG_RDATA_OUT == 8'h00)
        else $error("unmapped read not zero");

    half_lsb_on_a: assert property ( // RL3
        !$past(RST_IN) && $past(regs[SMBR_IX_MOD][5] &&
        !regs[SMBR_IX_MOD][4]) |-> CTRL_OUT.half_lsb_add)
        else $error("half LSB missing with aux off");
endmodule

// ===== verification/smbr_host.sv
// Host model driving the register port of the bias register slice.
// Assumes the device shares its clock and takes one-cycle strobes.
`timescale 1ns/100ps
module smbr_host
    import smbr_pkg::*;
(
    input wire logic clk_in, // Core clock
    input wire logic [7:0] rdata_in, // Read data
    input wire logic rvalid_in, // Read valid pulse
    output logic wr_out, // Write strobe
    output logic rd_out, // Read strobe
    output logic [7:0] addr_out, // Register address
    output logic [7:0] wdata_out // Write data
);
    // Idle port at time zero
    initial begin
        wr_out = 1'b0;
        rd_out = 1'b0;
        addr_out = 8'h00;
        wdata_out = 8'h00;
    end
    // One write, taken at the edge after it is raised
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        wr_out <= 1'b1;
        addr_out <= a;
        wdata_out <= d;
        @(posedge clk_in);
        wr_out <= 1'b0;
        addr_out <= ~a;
        wdata_out <= ~d;
    endtask
    // Valid pulse and data, looked at just after the edge taking the read
    task automatic take_rd(output logic [7:0] d, output logic ok);
        ok = 1'b0;
        d = 8'h00;
        for (int i = 0; i < 4 && !ok; i++) begin
            #1;
            ok = (rvalid_in === 1'b1);
            d = rdata_in;
            if (!ok) begin
                @(posedge clk_in);
            end
        end
    endtask
    // One read, data picked up with the valid pulse
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d,
        output logic ok);
        @(posedge clk_in);
        rd_out <= 1'b1;
        addr_out <= a;
        @(posedge clk_in);
        rd_out <= 1'b0;
        take_rd(d, ok);
    endtask
    // Write, then a read of the same address on the very next cycle
    task automatic wr_rd_reg(input logic [7:0] a, input logic [7:0] w,
        output logic [7:0] d, output logic ok);
        @(posedge clk_in);
        wr_out <= 1'b1;
        addr_out <= a;
        wdata_out <= w;
        @(posedge clk_in);
        wr_out <= 1'b0;
        rd_out <= 1'b1;
        @(posedge clk_in);
        rd_out <= 1'b0;
        wdata_out <= ~w;
        take_rd(d, ok);
    endtask
    task automatic set_mod(input logic [7:0] f1, input logic [7:0] f2,
        input logic mask);
        wr_reg(SMBR_OFS_MOD, {3'b000, f2 != 8'h00, 1'b0, mask, 1'b0,
            (f1 == 8'h00) && (f2 == 8'h00)});
    endtask
endmodule

// ===== verification/testbench.sv
// Self-checking bench for the modulator and bias register slice.
// Assumes the host model drives the register port on the core clock.
`timescale 1ns/100ps
module testbench
    import smbr_pkg::*;
;
    localparam logic [7:0] VER = 8'h5A; // Arbitrary value
    localparam int PIX [7] = '{0, 0, 1, 1, 2, 3, 4}; // Pattern targets
    localparam logic [7:0] PV [7] = '{8'h21, 8'h08, 8'h20, 8'h30, 8'h6B,
        8'h1A, 8'h0A}; // Pattern values
    logic clk, rst, wr, rd, rvalid, modrst, ok; // Port signals
    logic [7:0] addr, wdata, vco, rdata, rb, d; // Port buses
    smbr_ctrl_t ctrl; // Decoded controls
    logic [7:0] sh [SMBR_NREG]; // Expected register contents
    int err_total, samples_checked; // Counters
    smbr_regs #(.VERSION_ID(VER)) uut (.CORE_CLK_IN(clk), .RST_IN(rst),
        .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_ADDR_IN(addr),
        .REG_WDATA_IN(wdata), .VCO_STATUS_IN(vco), .REG_RDATA_OUT(rdata),
        .REG_RVALID_OUT(rvalid), .READBACK_OUT(rb),
        .MOD_RESET_OUT(modrst), .CTRL_OUT(ctrl));
    smbr_host host (.clk_in(clk), .rdata_in(rdata), .rvalid_in(rvalid),
        .wr_out(wr), .rd_out(rd), .addr_out(addr), .wdata_out(wdata));
    // Clock, 10 ns period
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Expected controls from the register contents
    function automatic smbr_ctrl_t model();
        smbr_ctrl_t c;
        c.bleed_polarity = sh[0][5];
        c.latch_select_reserved = sh[0][3];
        c.half_lsb_add = sh[1][5] & ~sh[1][4];
        c.aux_modulator_enable = sh[1][4];
        c.modulator_run = ~sh[1][0];
        c.auto_bias_loop_run = ~sh[2][0];
        c.temp_cal_voltage_enable = sh[2][1];
        c.core_d = {sh[2][6], sh[2][5], sh[2][4:2]};
        c.core_c = {sh[3][4], sh[3][3], sh[3][2:0]};
        c.core_b = {sh[4][4], sh[4][3], sh[4][2:0]};
        return c;
    endfunction
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %0t byte got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chkc(input smbr_ctrl_t g, input smbr_ctrl_t e);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %0t ctrl got %h exp %h", $time, g, e);
        end
    endtask
    // Settle two edges, then check controls and readback
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
        chkc(ctrl, model());
        chk8(rb, sh[0][0] ? VER : vco);
    endtask
    task automatic put(input int i, input logic [7:0] v);
        host.wr_reg(SMBR_OFS_BLEED + 8'(i), v);
        sh[i] = v & SMBR_WMASK[i];
        settle();
    endtask
    task automatic get(input logic [7:0] a, input logic [7:0] e);
        host.rd_reg(a, d, ok);
        took(e);
    endtask
    // Read result, or the closing report when no valid pulse came
    task automatic took(input logic [7:0] e);
        if (!ok) begin
            err_total++;
            conclude();
        end else begin
            chk8(d, e);
        end
    endtask
    task automatic conclude();
        $display("errors %0d checks %0d", err_total, samples_checked);
        if (err_total == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Main sequence
    initial begin
        rst = 1'b1;
        vco = 8'h3C;
        err_total = 0;
        samples_checked = 0;
        for (int r = 0; r < 2; r++) begin
            repeat (15) @(posedge clk);
            #1;
            chkc(ctrl, '0);
            @(posedge clk);
            rst <= 1'b0;
            sh = SMBR_RESET;
            settle();
            for (int i = 0; i < SMBR_NREG; i++) begin
                get(SMBR_OFS_BLEED + 8'(i), sh[i]);
                put(i, 8'hFF);
                get(SMBR_OFS_BLEED + 8'(i), sh[i]);
                put(i, 8'h00);
            end
            @(posedge clk);
            rst <= 1'b1;
        end
        @(posedge clk);
        rst <= 1'b0;
        sh = SMBR_RESET;
        vco <= 8'hC3;
        settle();
        for (int k = 0; k < 7; k++) put(PIX[k], PV[k]);
        host.wr_reg(8'h2F, 8'hFF);
        settle();
        get(8'h2F, 8'h00);
        get(8'h29, 8'h00);
        host.wr_rd_reg(SMBR_OFS_MOD, 8'hFF, d, ok);
        sh[1] = SMBR_WMASK[SMBR_IX_MOD];
        took(sh[1]);
        settle();
        for (int m = 0; m < 4; m++) begin
            host.set_mod(8'(m & 1), 8'(m & 2), m[1]);
            sh[1] = {3'b000, m[1], 1'b0, m[1], 1'b0, m == 0};
            settle();
            host.wr_reg(SMBR_OFS_FRAC, 8'h77);
            #1;
            chk8(8'(modrst), 8'(!m[1]));
            @(posedge clk);
            #1;
            chk8(8'(modrst), 8'h00);
        end
        conclude();
    end
endmodule
